//--- design/pse_general_mask_config.sv
// general mask and configuration register with its link port and the logic it steers
// Notes on behaviour
// - the register answers command 17h with one data byte and can be both read and written.
// - with the interrupt gate bit 7 clear the interrupt output stays inactive whatever the masks.
// - with the gate bit set any unmasked pending interrupt bit drives the interrupt output active.
// - the gate bit only gates the output pin and never touches event register contents.
// - with bit 5 set transfers are 16 bits wide and only the target with address bit zero low answers.
// - with bit 5 clear the part acts as two four-channel targets at two addresses, 8 bits each.
// - with bit 4 set the 3-bit shutdown priorities from the two wide priority registers are used.
// - with bit 4 clear the 1-bit shutdown priorities from the single priority register are used.
// - with bit 3 set a class event flag fires only when the class result changed.
// - with bit 3 clear a class event flag fires after every finished classification.
// - bit 2 does the same for detection event flags: change only when set, every finished detection when clear.
// - a limit, overload, dropout or start fault clears that channel's power good and enable flags.
// - the current-limit fault time is never shorter than the compliance floor.
// - the dropout field selects 360 ms for 00, 90 ms for 01 and 180 ms for 10 and 11.
`timescale 1ns/1ps
`default_nettype none
module pse_general_mask_config #(
	parameter int CH        = 8,
	parameter int CLASS_W   = 4,
	parameter int DET_W     = 3,
	parameter int SHED_IDLE = pse_pkg::SHED_IDLE_US * pse_pkg::CORE_CLK_MHZ
) (
	input  wire logic                 core_clk_in,
	input  wire logic                 reset_n_in,
	// link side, on its own clock
	input  wire logic                 link_clk_in,
	input  wire logic                 link_req_in,
	input  wire logic                 link_write_in,
	input  wire logic [7:0]           link_cmd_in,
	input  wire logic                 link_addr_lsb_in,
	input  wire logic [15:0]          link_wdata_in,
	output logic                      link_busy_out,
	output logic                      link_done_out,
	output logic                      link_hit_out,
	output logic [15:0]               link_rdata_out,
	// interrupt gating
	input  wire logic [7:0]           irq_pending_in,
	input  wire logic [7:0]           irq_mask_in,
	output logic                      irq_n_out,
	// configuration seen by the rest of the part
	output logic                      wide_access_sel_out,
	output logic                      multi_level_shed_sel_out,
	// shutdown priority
	input  wire logic [CH-1:0]        prio_1bit_in,
	input  wire logic [3*CH-1:0]      prio_3bit_in,
	output logic      [3*CH-1:0]      shed_prio_out,
	input  wire logic                 fast_shed_in,
	output logic                      fast_shed_idle_out,
	// detection and classification events
	input  wire logic [CH-1:0]        class_done_in,
	input  wire logic [CH*CLASS_W-1:0] class_result_in,
	input  wire logic [CH-1:0]        detect_done_in,
	input  wire logic [CH*DET_W-1:0]  detect_result_in,
	output logic      [CH-1:0]        class_event_flag_out,
	output logic      [CH-1:0]        detect_event_flag_out,
	// power status
	input  wire logic [CH-1:0]        power_good_set_in,
	input  wire logic [CH-1:0]        power_enable_set_in,
	input  wire logic [CH-1:0]        limit_fault_in,
	input  wire logic [CH-1:0]        overload_fault_in,
	input  wire logic [CH-1:0]        dropout_fault_in,
	input  wire logic [CH-1:0]        start_fault_in,
	output logic      [CH-1:0]        power_good_flag_out,
	output logic      [CH-1:0]        power_enable_flag_out,
	// fault time decoding
	input  wire logic [1:0]           hold_dropout_time_in,
	input  wire logic [1:0]           limit_fault_time_in,
	output logic      [9:0]           hold_dropout_ms_out,
	output logic      [9:0]           limit_fault_ms_out
);
	// ****************************************************************
	// link domain: capture a request and hand it over by toggle
	// ****************************************************************
	pse_pkg::pse_link_req_t  link_req_reg;
	pse_pkg::pse_link_resp_t resp_reg;
	logic                    link_busy_reg;
	logic                    link_done_reg;
	logic                    link_hit_reg;
	logic [15:0]             link_rdata_reg;
	logic                    req_tgl_reg;
	logic                    ack_tgl_reg;
	logic                    ack_seen_reg;
	logic                    ack_sync;
	wire link_take = link_req_in && !link_busy_reg;
	wire ack_event = ack_sync != ack_seen_reg;
	pse_sync2 #(.W(1)) u_ack_sync (
		.clk_in     (link_clk_in),
		.reset_n_in (reset_n_in),
		.d_in       (ack_tgl_reg),
		.q_out      (ack_sync)
	);
	always_ff @(posedge link_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			link_req_reg  <= '0;
			link_busy_reg <= 1'b0;
			req_tgl_reg   <= 1'b0;
		end
		else if (link_take)
		begin
			link_req_reg  <= '{link_write_in, link_cmd_in, link_addr_lsb_in, link_wdata_in};
			link_busy_reg <= 1'b1;
			req_tgl_reg   <= ~req_tgl_reg;
		end
		else if (ack_event)
		begin
			link_busy_reg <= 1'b0;
		end
	end
	// the answer bundle is written on the same core edge as the ack toggle and is stable until the next request
	always_ff @(posedge link_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			ack_seen_reg   <= 1'b0;
			link_done_reg  <= 1'b0;
			link_hit_reg   <= 1'b0;
			link_rdata_reg <= 16'h0000;
		end
		else
		begin
			ack_seen_reg  <= ack_sync;
			link_done_reg <= ack_event;
			if (ack_event)
			begin
				link_hit_reg   <= resp_reg.hit;
				link_rdata_reg <= resp_reg.rdata;
			end
		end
	end
	assign link_busy_out  = link_busy_reg;
	assign link_done_out  = link_done_reg;
	assign link_hit_out   = link_hit_reg;
	assign link_rdata_out = link_rdata_reg;

	// ****************************************************************
	// core domain: register access
	// ****************************************************************
	logic [7:0] gmc_reg;
	logic       req_seen_reg;
	logic       req_sync;
	pse_sync2 #(.W(1)) u_req_sync (
		.clk_in     (core_clk_in),
		.reset_n_in (reset_n_in),
		.d_in       (req_tgl_reg),
		.q_out      (req_sync)
	);
	wire       req_event  = req_sync != req_seen_reg;
	wire       gate_on    = gmc_reg[pse_pkg::GMC_IRQ_GATE_BIT];
	wire       wide_on    = gmc_reg[pse_pkg::GMC_WIDE_BIT];
	wire       multi_on   = gmc_reg[pse_pkg::GMC_MULTI_BIT];
	wire       class_chg  = gmc_reg[pse_pkg::GMC_CLASS_CHG_BIT];
	wire       det_chg    = gmc_reg[pse_pkg::GMC_DET_CHG_BIT];
	wire       cmd_match  = link_req_reg.cmd == pse_pkg::GMC_CMD;
	// in wide mode only the even target answers; narrow mode answers both halves
	wire       addr_ok    = !wide_on || !link_req_reg.addr_lsb;
	wire       access_hit = cmd_match && addr_ok;
	wire       do_write   = req_event && access_hit && link_req_reg.write;
	// only the low byte (channel 1-4 half) lands in the register, spares included
	wire [7:0] gmc_next   = do_write ? link_req_reg.wdata[7:0] : gmc_reg;
	// wide reads carry the value in both bytes, narrow reads in the low byte only
	wire [15:0] rdata_next = wide_on ? {gmc_next, gmc_next} : {8'h00, gmc_next};
	always_ff @(posedge core_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			gmc_reg      <= pse_pkg::GMC_RESET;
			req_seen_reg <= 1'b0;
			resp_reg     <= '0;
			ack_tgl_reg  <= 1'b0;
		end
		else
		begin
			gmc_reg      <= gmc_next;
			req_seen_reg <= req_sync;
			if (req_event)
			begin
				resp_reg    <= '{access_hit, rdata_next};
				ack_tgl_reg <= ~ack_tgl_reg;
			end
		end
	end
	assign wide_access_sel_out      = wide_on;
	assign multi_level_shed_sel_out = multi_on;

	// ****************************************************************
	// interrupt output gate
	// ****************************************************************
	// the gate sits after the masks only; events keep updating underneath
	wire  irq_any = |(irq_pending_in & ~irq_mask_in);
	logic irq_n_reg;
	always_ff @(posedge core_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			irq_n_reg <= 1'b1;
		else
			irq_n_reg <= ~(gate_on && irq_any);
	end
	assign irq_n_out = irq_n_reg;

	// ****************************************************************
	// fast shutdown idle watch
	// ****************************************************************
	// a 0-to-1 change of the multi-level bit is only safe after this goes high
	logic        shed_sync;
	logic [15:0] shed_cnt_reg;
	logic        shed_idle_reg;
	pse_sync2 #(.W(1)) u_shed_sync (
		.clk_in     (core_clk_in),
		.reset_n_in (reset_n_in),
		.d_in       (fast_shed_in),
		.q_out      (shed_sync)
	);
	wire shed_full = shed_cnt_reg >= 16'(SHED_IDLE);
	always_ff @(posedge core_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			shed_cnt_reg  <= 16'h0000;
			shed_idle_reg <= 1'b0;
		end
		else
		begin
			if (shed_sync)
				shed_cnt_reg <= 16'h0000;
			else if (!shed_full)
				shed_cnt_reg <= shed_cnt_reg + 16'h0001;
			shed_idle_reg <= !shed_sync && shed_full;
		end
	end
	assign fast_shed_idle_out = shed_idle_reg;

	// ****************************************************************
	// per-channel priority, events and power status
	// ****************************************************************
	logic [3*CH-1:0] prio_reg;
	for (genvar c = 0; c < CH; c++)
	begin : g_ch
		logic [CLASS_W-1:0] class_prev_reg;
		logic [DET_W-1:0]   det_prev_reg;
		logic               class_flag_reg;
		logic               det_flag_reg;
		logic               pg_reg;
		logic               pe_reg;
		wire [CLASS_W-1:0] class_now = class_result_in[c*CLASS_W +: CLASS_W];
		wire [DET_W-1:0]   det_now   = detect_result_in[c*DET_W +: DET_W];
		wire class_fire = class_done_in[c] && (!class_chg || class_now != class_prev_reg);
		wire det_fire   = detect_done_in[c] && (!det_chg || det_now != det_prev_reg);
		wire fault_any  = limit_fault_in[c] || overload_fault_in[c]
			|| dropout_fault_in[c] || start_fault_in[c];
		wire [2:0] prio_sel = multi_on ? prio_3bit_in[3*c +: 3] : {2'b00, prio_1bit_in[c]};
		always_ff @(posedge core_clk_in or negedge reset_n_in)
		begin
			if (!reset_n_in)
			begin
				class_prev_reg <= '0;
				det_prev_reg   <= '0;
				class_flag_reg <= 1'b0;
				det_flag_reg   <= 1'b0;
				prio_reg[3*c +: 3] <= 3'h0;
			end
			else
			begin
				if (class_done_in[c])
					class_prev_reg <= class_now;
				if (detect_done_in[c])
					det_prev_reg <= det_now;
				class_flag_reg <= class_fire;
				det_flag_reg   <= det_fire;
				prio_reg[3*c +: 3] <= prio_sel;
			end
		end
		// a fault in the same cycle as a set wins: power cannot be good while faulted
		always_ff @(posedge core_clk_in or negedge reset_n_in)
		begin
			if (!reset_n_in)
			begin
				pg_reg <= 1'b0;
				pe_reg <= 1'b0;
			end
			else if (fault_any)
			begin
				pg_reg <= 1'b0;
				pe_reg <= 1'b0;
			end
			else
			begin
				pg_reg <= pg_reg || power_good_set_in[c];
				pe_reg <= pe_reg || power_enable_set_in[c];
			end
		end
		assign class_event_flag_out[c]  = class_flag_reg;
		assign detect_event_flag_out[c] = det_flag_reg;
		assign power_good_flag_out[c]   = pg_reg;
		assign power_enable_flag_out[c] = pe_reg;
	end
	assign shed_prio_out = prio_reg;

	// ****************************************************************
	// fault time decoding
	// ****************************************************************
	wire [9:0] dropout_sel = (hold_dropout_time_in == 2'h0) ? pse_pkg::DROPOUT_MS_00
		: (hold_dropout_time_in == 2'h1) ? pse_pkg::DROPOUT_MS_01
		: pse_pkg::DROPOUT_MS_1X;
	wire [9:0] limit_raw = (limit_fault_time_in == 2'h0) ? pse_pkg::LIMIT_MS_00
		: (limit_fault_time_in == 2'h1) ? pse_pkg::LIMIT_MS_01
		: (limit_fault_time_in == 2'h2) ? pse_pkg::LIMIT_MS_10
		: pse_pkg::LIMIT_MS_11;
	// short codes are lifted to the floor rather than refused
	wire [9:0] limit_sel = (limit_raw < pse_pkg::LIMIT_MIN_MS) ? pse_pkg::LIMIT_MIN_MS
		: limit_raw;
	logic [9:0] dropout_reg;
	logic [9:0] limit_reg;
	always_ff @(posedge core_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			dropout_reg <= 10'h000;
			limit_reg   <= 10'h000;
		end
		else
		begin
			dropout_reg <= dropout_sel;
			limit_reg   <= limit_sel;
		end
	end
	assign hold_dropout_ms_out = dropout_reg;
	assign limit_fault_ms_out  = limit_reg;
endmodule
`default_nettype wire

//--- design/pse_pkg.sv
// constants and carrier types for the general mask and configuration register
package pse_pkg;

	// ****************************************************************
	// register location and layout
	// ****************************************************************
	localparam logic [7:0] GMC_CMD           = 8'h17;
	localparam int         GMC_IRQ_GATE_BIT  = 7;
	localparam int         GMC_SPARE6_BIT    = 6;
	localparam int         GMC_WIDE_BIT      = 5;
	localparam int         GMC_MULTI_BIT     = 4;
	localparam int         GMC_CLASS_CHG_BIT = 3;
	localparam int         GMC_DET_CHG_BIT   = 2;
	localparam int         GMC_SPARE1_BIT    = 1;
	localparam int         GMC_SPARE0_BIT    = 0;
	localparam logic [7:0] GMC_RESET         = 8'h80;

	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int CORE_CLK_MHZ = 25;
	localparam int SHED_IDLE_US = 200;

	// hold-power dropout times, ms, by field code
	localparam logic [9:0] DROPOUT_MS_00 = 10'h168;
	localparam logic [9:0] DROPOUT_MS_01 = 10'h05A;
	localparam logic [9:0] DROPOUT_MS_1X = 10'h0B4;

	// current-limit fault times, ms, by field code, and the compliance floor
	localparam logic [9:0] LIMIT_MS_00  = 10'h03C;
	localparam logic [9:0] LIMIT_MS_01  = 10'h00F;
	localparam logic [9:0] LIMIT_MS_10  = 10'h00C;
	localparam logic [9:0] LIMIT_MS_11  = 10'h00A;
	localparam logic [9:0] LIMIT_MIN_MS = 10'h032;

	// ****************************************************************
	// link carriers
	// ****************************************************************
	typedef struct packed
	{
		logic        write;
		logic [7:0]  cmd;
		logic        addr_lsb;
		logic [15:0] wdata;
	} pse_link_req_t;

	typedef struct packed
	{
		logic        hit;
		logic [15:0] rdata;
	} pse_link_resp_t;

endpackage

//--- design/pse_sync2.sv
// two-flop synchroniser for levels and toggles
`timescale 1ns/1ps
`default_nettype none
module pse_sync2 #(
	parameter int W = 1
) (
	input  wire logic         clk_in,
	input  wire logic         reset_n_in,
	input  wire logic [W-1:0] d_in,
	output logic      [W-1:0] q_out
);
	logic [W-1:0] meta_reg;
	logic [W-1:0] sync_reg;

	// the first stage feeds only the second
	always_ff @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			meta_reg <= '0;
			sync_reg <= '0;
		end
		else
		begin
			meta_reg <= d_in;
			sync_reg <= meta_reg;
		end
	end

	assign q_out = sync_reg;
endmodule
`default_nettype wire

//--- test/pse_gmc_properties.sv
// port-level assertions for the general mask and configuration register
`timescale 1ns/1ps
`default_nettype none
module pse_gmc_properties #(
	parameter int CH = 8
) (
	input wire logic            core_clk_in,
	input wire logic            reset_n_in,
	input wire logic            link_clk_in,
	input wire logic            link_busy_out,
	input wire logic            link_done_out,
	input wire logic [7:0]      irq_pending_in,
	input wire logic [7:0]      irq_mask_in,
	input wire logic            irq_n_out,
	input wire logic            multi_level_shed_sel_out,
	input wire logic [CH-1:0]   prio_1bit_in,
	input wire logic [3*CH-1:0] prio_3bit_in,
	input wire logic [3*CH-1:0] shed_prio_out,
	input wire logic [CH-1:0]   class_done_in,
	input wire logic [CH-1:0]   detect_done_in,
	input wire logic [CH-1:0]   class_event_flag_out,
	input wire logic [CH-1:0]   detect_event_flag_out,
	input wire logic [1:0]      hold_dropout_time_in,
	input wire logic [9:0]      hold_dropout_ms_out
);
	// ****
	// helper logic
	// ****
	logic [3*CH-1:0] one_bit_prio;
	logic [9:0]      dropout_exp;
	for (genvar i = 0; i < CH; i++)
	begin : g_prio
		assign one_bit_prio[3*i +: 3] = {2'b00, prio_1bit_in[i]};
	end
	assign dropout_exp = (hold_dropout_time_in == 2'h0) ? pse_pkg::DROPOUT_MS_00 :
		(hold_dropout_time_in == 2'h1) ? pse_pkg::DROPOUT_MS_01 : pse_pkg::DROPOUT_MS_1X;

	// ****
	// properties
	// ****
	sequence s_take;
		$rose(link_busy_out);
	endsequence
	sequence s_answer;
		##[1:12] link_done_out;
	endsequence
	property p_answer;
		@(posedge link_clk_in) disable iff (!reset_n_in) s_take |-> s_answer;
	endproperty
	property p_done;
		@(posedge link_clk_in) disable iff (!reset_n_in)
			$rose(link_done_out) |-> !link_busy_out && $past(link_busy_out);
	endproperty
	property p_irq;
		@(posedge core_clk_in) disable iff (!reset_n_in)
			!irq_n_out |-> $past(|(irq_pending_in & ~irq_mask_in));
	endproperty
	property p_prio3;
		@(posedge core_clk_in) disable iff (!reset_n_in) $past(reset_n_in)
			&& $past(multi_level_shed_sel_out) |-> shed_prio_out == $past(prio_3bit_in);
	endproperty
	property p_prio1;
		@(posedge core_clk_in) disable iff (!reset_n_in) $past(reset_n_in)
			&& !$past(multi_level_shed_sel_out) |-> shed_prio_out == $past(one_bit_prio);
	endproperty
	property p_class;
		@(posedge core_clk_in) disable iff (!reset_n_in)
			(class_event_flag_out & ~$past(class_done_in)) == '0;
	endproperty
	property p_detect;
		@(posedge core_clk_in) disable iff (!reset_n_in)
			detect_event_flag_out != '0 |-> $past(detect_done_in) != '0;
	endproperty
	property p_dropout;
		@(posedge core_clk_in) disable iff (!reset_n_in)
			$past(reset_n_in) |-> hold_dropout_ms_out == $past(dropout_exp);
	endproperty

	a_answer: assert property (p_answer) else $error("link answer late");
	a_done: assert property (p_done) else $error("done without busy");
	a_irq: assert property (p_irq) else $error("irq without cause");
	a_prio3: assert property (p_prio3) else $error("3-bit priority wrong");
	a_prio1: assert property (p_prio1) else $error("1-bit priority wrong");
	a_class: assert property (p_class) else $error("class flag unprompted");
	a_detect: assert property (p_detect) else $error("detect flag unprompted");
	a_dropout: assert property (p_dropout) else $error("dropout decode wrong");
endmodule

bind pse_general_mask_config pse_gmc_properties #(.CH(CH)) pse_gmc_properties_i (.*);
`default_nettype wire

//--- test/pse_link_host.sv
// link host model: frames the link clock and holds each request for one link clock cycle
`timescale 1ns/1ps
`default_nettype none
module pse_link_host (
	output logic        link_clk_out,
	output logic        req_out,
	output logic        write_out,
	output logic [7:0]  cmd_out,
	output logic        lsb_out,
	output logic [15:0] wdata_out,
	input  wire logic   done_in
);
	initial
	begin
		{link_clk_out, req_out, write_out, cmd_out, lsb_out, wdata_out} = '0;
	end

	// ****
	// transfer
	// ****
	// clock only runs inside a transfer; the odd offset keeps it off the core phase
	task automatic xfer(input logic wr, input logic [7:0] cmd, input logic lsb,
		input logic [15:0] wd, output logic ok);
		ok = 1'b0;
		#7;
		{req_out, write_out, cmd_out, lsb_out, wdata_out} = {1'b1, wr, cmd, lsb, wd};
		for (int n = 0; n < 20 && !ok; n++)
		begin
			#40 link_clk_out = 1'b1;
			ok = (n > 0) && (done_in === 1'b1);
			#40 link_clk_out = 1'b0;
			req_out = 1'b0;
		end
		// released command, data and write lines show the inverse, not the last value; the address bit keeps its value
		cmd_out = ~cmd;
		wdata_out = ~wd;
		write_out = ~wr;
	endtask
endmodule
`default_nettype wire

//--- test/tb.sv
// self-checking bench for the general mask and configuration register
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic core_clk_in, reset_n_in, link_clk_in, link_req_in, link_write_in, link_addr_lsb_in;
	logic link_busy_out, link_done_out, link_hit_out, irq_n_out, wide_access_sel_out;
	logic multi_level_shed_sel_out, fast_shed_in, fast_shed_idle_out;
	logic [7:0] link_cmd_in, irq_pending_in, irq_mask_in, prio_1bit_in, class_done_in;
	logic [7:0] detect_done_in, power_good_set_in, power_enable_set_in, limit_fault_in;
	logic [7:0] overload_fault_in, dropout_fault_in, start_fault_in, class_event_flag_out;
	logic [7:0] detect_event_flag_out, power_good_flag_out, power_enable_flag_out;
	logic [15:0] link_wdata_in, link_rdata_out;
	logic [23:0] prio_3bit_in, shed_prio_out, detect_result_in, p_exp;
	logic [31:0] class_result_in;
	logic [1:0]  hold_dropout_time_in, limit_fault_time_in;
	logic [9:0]  hold_dropout_ms_out, limit_fault_ms_out;
	logic [17:0] notes[$];
	logic [17:0] note;
	logic [7:0]  cur, pg, pe, f, cls_exp, det_exp;
	logic [7:0]  cfg_tbl[4] = '{8'h80, 8'h0C, 8'h8C, 8'h00};
	logic [3:0]  cls_prev[8] = '{default: 4'h0};
	logic [2:0]  det_prev[8] = '{default: 3'h0};
	logic [3:0]  r;
	int          fail_count;
	int          tests_run;
	int          ch;

	pse_general_mask_config #(.SHED_IDLE(20)) pse_general_mask_config_i (.*);
	pse_link_host pse_link_host_i (.link_clk_out(link_clk_in), .req_out(link_req_in),
		.write_out(link_write_in), .cmd_out(link_cmd_in), .lsb_out(link_addr_lsb_in),
		.wdata_out(link_wdata_in), .done_in(link_done_out));

	initial
	begin
		core_clk_in = 1'b0;
		forever #20 core_clk_in = ~core_clk_in;
	end

	// ****
	// shared tasks
	// ****
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			fail_count++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks=%0d errors=%0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic nxt();
		@(negedge core_clk_in);
	endtask

	// note layout: rdata care, hit, rdata
	function automatic logic [17:0] form(input logic hit, input logic [7:0] v);
		return {1'b1, hit, cur[5] ? v : 8'h00, v};
	endfunction

	task automatic op(input logic wr, input logic [7:0] cmd, input logic lsb,
		input logic [15:0] wd, input logic [17:0] exp);
		logic ok;
		notes.push_back(exp);
		pse_link_host_i.xfer(wr, cmd, lsb, wd, ok);
		if (!ok)
		begin
			fail_count++;
			tally_and_finish();
		end
		nxt();
	endtask

	// a write's own read-back is framed by the width in force before it lands
	task automatic wr(input logic [7:0] v);
		logic [17:0] e;
		e = form(1'b1, v);
		cur = v;
		op(1'b1, 8'h17, 1'b0, {8'h00, v}, e);
		nxt();
	endtask

	always @(posedge link_clk_in)
	begin
		if (link_done_out === 1'b1)
		begin
			note = notes.pop_front();
			chk({link_hit_out, note[17] ? link_rdata_out : 16'h0000}, note[16:0]);
		end
	end

	// ****
	// main sequence
	// ****
	initial
	begin
		fail_count = 0;
		tests_run = 0;
		cur = 8'h80;
		{reset_n_in, irq_pending_in, irq_mask_in, prio_1bit_in, prio_3bit_in, fast_shed_in,
			class_done_in, class_result_in, detect_done_in, detect_result_in, power_good_set_in,
			power_enable_set_in, limit_fault_in, overload_fault_in, dropout_fault_in,
			start_fault_in, hold_dropout_time_in, limit_fault_time_in} = '0;
		void'($urandom(32'hF8935B1B));
		repeat (12) nxt();
		reset_n_in = 1'b1;
		nxt();
		op(1'b0, 8'h17, 1'b0, 16'h0000, form(1'b1, 8'h80));
		op(1'b0, 8'h17, 1'b1, 16'h0000, form(1'b1, 8'h80));
		wr(8'hC3);
		chk({wide_access_sel_out, multi_level_shed_sel_out}, 2'b00);
		op(1'b1, 8'h16, 1'b0, 16'h00FF, 18'h00000);
		op(1'b0, 8'h17, 1'b0, 16'h0000, form(1'b1, 8'hC3));
		foreach (cfg_tbl[k])
		begin
			wr(cfg_tbl[k]);
			repeat (12)
			begin
				irq_pending_in = 8'($urandom);
				irq_mask_in = 8'($urandom);
				ch = $urandom % 8;
				r = 4'($urandom % 2);
				class_result_in[ch*4 +: 4] = r;
				detect_result_in[ch*3 +: 3] = r[2:0];
				class_done_in = 8'h01 << ch;
				detect_done_in = 8'h01 << ch;
				cls_exp = (!cur[3] || cls_prev[ch] != r) ? class_done_in : 8'h00;
				det_exp = (!cur[2] || det_prev[ch] != r[2:0]) ? detect_done_in : 8'h00;
				cls_prev[ch] = r;
				det_prev[ch] = r[2:0];
				nxt();
				chk(irq_n_out, !(cur[7] && |(irq_pending_in & ~irq_mask_in)));
				chk(class_event_flag_out, cls_exp);
				chk(detect_event_flag_out, det_exp);
			end
			{class_done_in, detect_done_in} = 16'h0000;
		end
		fast_shed_in = 1'b1;
		repeat (5) nxt();
		chk(fast_shed_idle_out, 1'b0);
		fast_shed_in = 1'b0;
		repeat (30) nxt();
		chk(fast_shed_idle_out, 1'b1);
		for (int m = 0; m < 2; m++)
		begin
			wr(m ? 8'h90 : 8'h80);
			chk(multi_level_shed_sel_out, m[0]);
			repeat (4)
			begin
				prio_1bit_in = 8'($urandom);
				prio_3bit_in = 24'($urandom);
				for (int c = 0; c < 8; c++)
					p_exp[c*3 +: 3] = m ? prio_3bit_in[c*3 +: 3] : {2'b00, prio_1bit_in[c]};
				nxt();
				chk(shed_prio_out, p_exp);
			end
		end
		wr(8'h20);
		chk(wide_access_sel_out, 1'b1);
		op(1'b0, 8'h17, 1'b0, 16'h0000, form(1'b1, 8'h20));
		op(1'b0, 8'h17, 1'b1, 16'h0000, 18'h00000);
		op(1'b1, 8'h17, 1'b1, 16'h00FF, 18'h00000);
		op(1'b0, 8'h17, 1'b0, 16'h0000, form(1'b1, 8'h20));
		wr(8'h00);
		chk(wide_access_sel_out, 1'b0);
		op(1'b0, 8'h17, 1'b1, 16'h0000, form(1'b1, 8'h00));
		pg = 8'h00;
		pe = 8'h00;
		repeat (8)
		begin
			power_good_set_in = 8'($urandom);
			power_enable_set_in = 8'($urandom);
			{limit_fault_in, overload_fault_in, dropout_fault_in, start_fault_in} = $urandom & $urandom;
			f = limit_fault_in | overload_fault_in | dropout_fault_in | start_fault_in;
			pg = (pg | power_good_set_in) & ~f;
			pe = (pe | power_enable_set_in) & ~f;
			nxt();
			chk(power_good_flag_out, pg);
			chk(power_enable_flag_out, pe);
		end
		for (int c = 0; c < 4; c++)
		begin
			hold_dropout_time_in = c[1:0];
			limit_fault_time_in = c[1:0];
			nxt();
			chk(hold_dropout_ms_out, (c == 0) ? 10'h168 : (c == 1) ? 10'h05A : 10'h0B4);
			chk(limit_fault_ms_out, (c == 0) ? pse_pkg::LIMIT_MS_00 : pse_pkg::LIMIT_MIN_MS);
		end
		chk(notes.size(), 0);
		tally_and_finish();
	end
endmodule
`default_nettype wire
